// ===== aise_cfg.sv
// Fault response settings with validation and store
`include "aise_map.svh"

module aise_cfg (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       oc_wr,
  input  wire logic       ot_wr,
  input  wire logic [7:0] wr_data,
  input  wire logic       store_cmd,
  output logic [7:0]      oc_resp,
  output logic [7:0]      ot_resp,
  output logic            resp_reject,
  output logic            nv_wr,
  output logic [15:0]     nv_data
);
  // Over-current code check
  function automatic logic oc_ok(input logic [7:0] v);
    oc_ok = (v == `AISE_OC_LATCHED) || (v == `AISE_OC_HICCUP);
  endfunction : oc_ok

  // Over-temperature code check
  function automatic logic ot_ok(input logic [7:0] v);
    ot_ok = (v == `AISE_OT_LATCHED) || (v == `AISE_OT_RESTART);
  endfunction : ot_ok

  // Settings update, unsupported codes leave them unchanged
  always_ff @(posedge mclk) begin
    if (rst) begin
      oc_resp     <= `AISE_OC_RESP_RST;
      ot_resp     <= `AISE_OT_RESP_RST;
      resp_reject <= 1'b0;
    end else begin
      resp_reject <= (oc_wr && !oc_ok(wr_data)) ||
                     (ot_wr && !ot_ok(wr_data));
      if (oc_wr && oc_ok(wr_data)) begin
        oc_resp <= wr_data;
      end
      if (ot_wr && ot_ok(wr_data)) begin
        ot_resp <= wr_data;
      end
    end
  end

  // Store command copies settings to non-volatile memory
  always_ff @(posedge mclk) begin
    if (rst) begin
      nv_wr   <= 1'b0;
      nv_data <= 16'h0;
    end else begin
      nv_wr <= store_cmd;
      if (store_cmd) begin
        nv_data <= {ot_resp, oc_resp};
      end
    end
  end
endmodule : aise_cfg

// ===== aise_map.svh
// Constants for the alarm indicator status encoder
`ifndef AISE_MAP_SVH
`define AISE_MAP_SVH

// Accepted fault response codes
`define AISE_OC_LATCHED     8'hc0
`define AISE_OC_HICCUP      8'hf8
`define AISE_OT_LATCHED     8'h80
`define AISE_OT_RESTART     8'hc0

// Reset values of the response settings
`define AISE_OC_RESP_RST    8'hf8
`define AISE_OT_RESP_RST    8'hc0

// Clock rate and timing figures
`define AISE_CLK_HZ         25000000
`define AISE_PG_PULSE_US    1000
`define AISE_BLINK_HALF_MS  500
`define AISE_PG_CYCLES      ((`AISE_CLK_HZ / 1000000) * `AISE_PG_PULSE_US)
`define AISE_BLINK_CYCLES   ((`AISE_CLK_HZ / 1000) * `AISE_BLINK_HALF_MS)

// Field positions of the address nibble
`define AISE_ADDR_FIRST_LSB  2
`define AISE_ADDR_SECOND_LSB 0

`endif

// ===== aise_pkg.sv
// Types shared by the alarm indicator status encoder
package aise_pkg;

  // Raw conditions reported by the rectifier control
  typedef struct packed {
    logic ot_warn;          // Temperature near shutdown
    logic ot_shutdown;      // Thermal shutdown
    logic fuse_blown;       // Input fuse open
    logic boost_fail;       // Boost stage failure
    logic ov_latched;       // Latched over-voltage shutdown
    logic ac_bad;           // Input present, out of limits
    logic ac_absent;        // No input
    logic overload;         // Output overload
    logic internal_fault;   // Fault without shutdown
    logic service_req;      // Service request pending
    logic comm_lost;        // Host link lost
    logic remote_standby;   // Standby commanded over bus
    logic loss_imminent;    // Output about to collapse
  } aise_cond_t;

  // Front lamps, active high
  typedef struct packed {
    logic ac_ok;            // Green input lamp
    logic dc_ok;            // Green output lamp
    logic amber;            // Service lamp
    logic red;              // Fault lamp
  } aise_lamps_t;

  // Communications mode
  typedef enum logic {
    AISE_MODE_BUS,
    AISE_MODE_RS485
  } aise_mode_t;

  // Indicator state after priority encoding
  typedef enum {
    IND_OK,
    IND_OT_WARN,
    IND_OT_SHUT,
    IND_HARD_FAULT,
    IND_AC_BAD,
    IND_AC_ABSENT,
    IND_OVERLOAD,
    IND_SOFT_FAULT,
    IND_BUS_STANDBY,
    IND_SERVICE,
    IND_COMM_LOST,
    IND_RS_STANDBY
  } aise_ind_t;

endpackage : aise_pkg

// ===== aise_shelf.sv
// Shelf controller model driving the control pins
module aise_shelf (
  input  wire logic       req_rs485,
  input  wire logic       req_on,
  input  wire logic [3:0] req_addr,
  output logic            protocol_terminated,
  output logic            on_off_at_ground,
  output logic            interlock_on,
  output logic [1:0]      addr_sel_first,
  output logic [1:0]      addr_sel_second
);
  timeunit 1ns;
  timeprecision 1ps;
  // Terminated protocol pin picks RS485
  assign protocol_terminated = req_rs485;
  // Bus mode switches by the control pin
  assign on_off_at_ground = req_on & ~req_rs485;
  // RS485 mode switches by the interlock
  assign interlock_on = req_on & req_rs485;
  // Two level selections, first then second
  assign {addr_sel_first, addr_sel_second} = req_addr;
endmodule : aise_shelf

// ===== aise_tick.sv
// Blink toggle and power-good pulse divider
`include "aise_map.svh"

module aise_tick #(
  parameter int BLINK_CYCLES = `AISE_BLINK_CYCLES,
  parameter int PG_CYCLES    = `AISE_PG_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst,
  output logic      blink,
  output logic      pg_phase
);
  // Refuse counts that the counters cannot serve
  if (BLINK_CYCLES < 2 || PG_CYCLES < 2) begin : g_bad_counts
    $error("aise_tick: counts must be at least 2");
  end

  logic [31:0] blink_cnt_reg;   // Blink half-period counter
  logic [31:0] pg_cnt_reg;      // Pulse half-period counter

  // Shared blink toggle for all lamps
  always_ff @(posedge mclk) begin
    if (rst) begin
      blink_cnt_reg <= 32'h0;
      blink         <= 1'b0;
    end else if (blink_cnt_reg == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_reg <= 32'h0;
      blink         <= ~blink;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // Power-good pulse phase, 1 ms per level
  always_ff @(posedge mclk) begin
    if (rst) begin
      pg_cnt_reg <= 32'h0;
      pg_phase   <= 1'b1;
    end else if (pg_cnt_reg == 32'(PG_CYCLES - 1)) begin
      pg_cnt_reg <= 32'h0;
      pg_phase   <= ~pg_phase;
    end else begin
      pg_cnt_reg <= pg_cnt_reg + 32'h1;
    end
  end
endmodule : aise_tick

// ===== aise_top.sv
// Alarm, lamp and monitoring line encoder of the rectifier
`include "aise_map.svh"

module aise_top #(
  parameter int BLINK_CYCLES = `AISE_BLINK_CYCLES,
  parameter int PG_CYCLES    = `AISE_PG_CYCLES
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire aise_pkg::aise_cond_t cond,
  input  wire logic            on_off_at_ground,
  input  wire logic            interlock_on,
  input  wire logic            off_cmd,
  input  wire logic            on_cmd,
  input  wire logic            protocol_terminated,
  input  wire logic [1:0]      addr_sel_first,
  input  wire logic [1:0]      addr_sel_second,
  input  wire logic            clear_faults,
  input  wire logic            oc_wr,
  input  wire logic            ot_wr,
  input  wire logic [7:0]      wr_data,
  input  wire logic            store_cmd,
  output aise_pkg::aise_lamps_t lamps,
  output logic                 fault_n,
  output logic                 overtemp_warn_n,
  output logic                 power_good_n,
  output logic                 module_present_n,
  output logic [1:0]           alert_n,
  output logic                 main_out_en,
  output aise_pkg::aise_mode_t mode,
  output logic [3:0]           addr_low,
  output logic [8:0]           fault_status,
  output logic [7:0]           oc_resp,
  output logic [7:0]           ot_resp,
  output logic                 resp_reject,
  output logic                 nv_wr,
  output logic [15:0]          nv_data
);
  import aise_pkg::*;

  // Refuse counts that the dividers cannot serve
  if (BLINK_CYCLES < 2 || PG_CYCLES < 2) begin : g_bad_counts
    $error("aise_top: counts must be at least 2");
  end

  logic        blink;            // Shared blink toggle
  logic        pg_phase;         // Overload pulse level
  logic        off_req_reg;      // Off command held
  logic        out_en_next;      // Output enable decision
  logic [8:0]  fault_now;        // Live fault flags
  logic [8:0]  fault_reg;        // Sticky fault flags
  aise_ind_t   ind;              // Encoded indicator state
  aise_lamps_t lamps_next;       // Lamp values
  logic        fault_n_next;     // Fault line value
  logic        otw_n_next;       // Warning line value
  logic        pg_n_next;        // Power-good line value
  aise_mode_t  mode_next;        // Decoded mode

  // Divider for blink and overload pulse
  aise_tick #(
    .BLINK_CYCLES (BLINK_CYCLES),
    .PG_CYCLES    (PG_CYCLES)
  ) u_tick (
    .mclk     (mclk),
    .rst      (rst),
    .blink    (blink),
    .pg_phase (pg_phase)
  );

  // Fault response settings
  aise_cfg u_cfg (
    .mclk        (mclk),
    .rst         (rst),
    .oc_wr       (oc_wr),
    .ot_wr       (ot_wr),
    .wr_data     (wr_data),
    .store_cmd   (store_cmd),
    .oc_resp     (oc_resp),
    .ot_resp     (ot_resp),
    .resp_reject (resp_reject),
    .nv_wr       (nv_wr),
    .nv_data     (nv_data)
  );

  // Mode from the protocol pin
  always_comb begin
    if (protocol_terminated) begin
      mode_next = AISE_MODE_RS485;
    end else begin
      mode_next = AISE_MODE_BUS;
    end
  end

  // Off command held until an on command
  always_ff @(posedge mclk) begin
    if (rst) begin
      off_req_reg <= 1'b0;
    end else if (off_cmd) begin
      off_req_reg <= 1'b1;
    end else if (on_cmd) begin
      off_req_reg <= 1'b0;
    end
  end

  // Output enable per mode
  always_comb begin
    if (mode_next == AISE_MODE_RS485) begin
      out_en_next = interlock_on && !off_req_reg;
    end else begin
      out_en_next = on_off_at_ground;
    end
  end

  // Live fault flags for the sticky status
  assign fault_now = {cond.ot_warn, cond.ot_shutdown, cond.fuse_blown,
                      cond.boost_fail, cond.ov_latched, cond.ac_bad,
                      cond.ac_absent, cond.overload, cond.internal_fault};

  // Sticky faults, a present fault wins over a clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_reg <= 9'h000;
    end else if (clear_faults) begin
      fault_reg <= fault_now;
    end else begin
      fault_reg <= fault_reg | fault_now;
    end
  end

  // Priority encoding of the indicator state, highest first:
  // thermal shutdown, latched power faults, missing then bad input,
  // RS485 standby (output off), bus standby, overload, soft fault,
  // temperature warning, lost host link, service request.
  // Standby outranks overload since an idle output cannot overload.
  // Link loss counts only in RS485 mode, service only in bus mode.
  always_comb begin
    if (cond.ot_shutdown) begin
      ind = IND_OT_SHUT;
    end else if (cond.fuse_blown || cond.boost_fail || cond.ov_latched) begin
      ind = IND_HARD_FAULT;
    end else if (cond.ac_absent) begin
      ind = IND_AC_ABSENT;
    end else if (cond.ac_bad) begin
      ind = IND_AC_BAD;
    end else if (mode_next == AISE_MODE_RS485 && !out_en_next) begin
      ind = IND_RS_STANDBY;
    end else if (mode_next == AISE_MODE_BUS && cond.remote_standby) begin
      ind = IND_BUS_STANDBY;
    end else if (cond.overload) begin
      ind = IND_OVERLOAD;
    end else if (cond.internal_fault) begin
      ind = IND_SOFT_FAULT;
    end else if (cond.ot_warn) begin
      ind = IND_OT_WARN;
    end else if (mode_next == AISE_MODE_RS485 && cond.comm_lost) begin
      ind = IND_COMM_LOST;
    end else if (mode_next == AISE_MODE_BUS && cond.service_req) begin
      ind = IND_SERVICE;
    end else begin
      ind = IND_OK;
    end
  end

  // Lamp and monitoring line values per state
  always_comb begin
    // Defaults give the normal pattern
    lamps_next   = '{ac_ok: 1'b1, dc_ok: 1'b1, amber: 1'b0, red: 1'b0};
    fault_n_next = 1'b1;
    otw_n_next   = 1'b1;
    pg_n_next    = 1'b1;
    case (ind)
      IND_OK: begin
        // Greens lit, lines high
        lamps_next.ac_ok = 1'b1;
      end
      IND_OT_WARN: begin
        // Amber on, warning line low
        lamps_next.amber = 1'b1;
        otw_n_next       = 1'b0;
      end
      IND_OT_SHUT: begin
        // Output off, amber and red, all lines low
        lamps_next.dc_ok = 1'b0;
        lamps_next.amber = 1'b1;
        lamps_next.red   = 1'b1;
        fault_n_next     = 1'b0;
        otw_n_next       = 1'b0;
        pg_n_next        = 1'b0;
      end
      IND_HARD_FAULT: begin
        // Output off, red, warning line untouched
        lamps_next.dc_ok = 1'b0;
        lamps_next.red   = 1'b1;
        fault_n_next     = 1'b0;
        pg_n_next        = 1'b0;
      end
      IND_AC_BAD: begin
        // Input lamp blinks, output lamp dark
        lamps_next.ac_ok = blink;
        lamps_next.dc_ok = 1'b0;
        pg_n_next        = 1'b0;
      end
      IND_AC_ABSENT: begin
        // All lamps dark, fault line high
        lamps_next.ac_ok = 1'b0;
        lamps_next.dc_ok = 1'b0;
        pg_n_next        = 1'b0;
      end
      IND_OVERLOAD: begin
        // Output lamp blinks, power good pulses
        lamps_next.dc_ok = blink;
        pg_n_next        = pg_phase;
      end
      IND_SOFT_FAULT: begin
        // Output stays on, red and fault line
        lamps_next.red = 1'b1;
        fault_n_next   = 1'b0;
      end
      IND_BUS_STANDBY: begin
        // Input lamp only, power good low
        lamps_next.dc_ok = 1'b0;
        pg_n_next        = 1'b0;
      end
      IND_SERVICE: begin
        // Amber blinks, greens lit
        lamps_next.amber = blink;
      end
      IND_COMM_LOST: begin
        // Red blinks, greens lit
        lamps_next.red = blink;
      end
      IND_RS_STANDBY: begin
        // Input lamp only, lines fixed at fault 1, warn 1, good 0
        lamps_next.dc_ok = 1'b0;
        pg_n_next        = 1'b0;
      end
      default: begin
        lamps_next = '0;
      end
    endcase
    // Warning line follows the warning wherever it is not masked
    if (cond.ot_warn && ind != IND_RS_STANDBY) begin
      otw_n_next = 1'b0;
    end
    // Imminent loss pulls power good low first
    if (cond.loss_imminent || !out_en_next) begin
      // RS485 standby keeps its fixed line pattern
      if (ind != IND_RS_STANDBY) begin
        pg_n_next = 1'b0;
      end
    end
  end

  // Registered lamps and monitoring lines
  always_ff @(posedge mclk) begin
    if (rst) begin
      lamps           <= '0;
      fault_n         <= 1'b1;
      overtemp_warn_n <= 1'b1;
      power_good_n    <= 1'b0;
    end else begin
      lamps           <= lamps_next;
      fault_n         <= fault_n_next;
      overtemp_warn_n <= otw_n_next;
      power_good_n    <= pg_n_next;
    end
  end

  // Module present is always low
  always_ff @(posedge mclk) begin
    if (rst) begin
      module_present_n <= 1'b0;
    end else begin
      module_present_n <= 1'b0;
    end
  end

  // Interrupts low while any sticky fault is held
  always_ff @(posedge mclk) begin
    if (rst) begin
      alert_n <= 2'b11;
    end else begin
      alert_n <= {2{~(|fault_reg)}};
    end
  end

  // Mode, output enable and address registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode        <= AISE_MODE_BUS;
      main_out_en <= 1'b0;
      addr_low    <= 4'h0;
    end else begin
      mode        <= mode_next;
      main_out_en <= out_en_next;
      addr_low[`AISE_ADDR_FIRST_LSB +: 2]  <= addr_sel_first;
      addr_low[`AISE_ADDR_SECOND_LSB +: 2] <= addr_sel_second;
    end
  end

  // Sticky status visible to the controller
  assign fault_status = fault_reg;

endmodule : aise_top

// ===== aise_top_asserts.sv
// Concurrent checks on the status encoder ports
module aise_chk #(
  parameter int BLINK_CYCLES = 8,
  parameter int PG_CYCLES    = 4
) (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire aise_pkg::aise_cond_t  cond,
  input wire logic                  on_off_at_ground,
  input wire logic                  interlock_on,
  input wire logic                  protocol_terminated,
  input wire logic [1:0]            addr_sel_first,
  input wire logic [1:0]            addr_sel_second,
  input wire logic                  oc_wr,
  input wire logic                  ot_wr,
  input wire logic [7:0]            wr_data,
  input wire logic                  store_cmd,
  input wire aise_pkg::aise_lamps_t lamps,
  input wire logic                  fault_n,
  input wire logic                  power_good_n,
  input wire logic                  module_present_n,
  input wire logic [1:0]            alert_n,
  input wire logic                  main_out_en,
  input wire aise_pkg::aise_mode_t  mode,
  input wire logic [3:0]            addr_low,
  input wire logic [8:0]            fault_status,
  input wire logic [7:0]            oc_resp,
  input wire logic [7:0]            ot_resp,
  input wire logic                  resp_reject,
  input wire logic                  nv_wr,
  input wire logic [15:0]           nv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import aise_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [15:0] ovl_reg;  // Cycles of overload alone
  logic [15:0] run_reg;  // Cycles power good held
  logic        pg_reg;   // Power good one cycle ago
  logic [15:0] blk_reg;  // Cycles output lamp held
  logic        dc_reg;   // Output lamp one cycle ago
  // Overload age and length of each power good level
  always_ff @(posedge mclk) begin
    if (rst) begin
      ovl_reg <= 16'h0;
      run_reg <= 16'h0;
      pg_reg  <= 1'b0;
      blk_reg <= 16'h0;
      dc_reg  <= 1'b0;
    end else begin
      blk_reg <= (lamps.dc_ok == dc_reg) ? blk_reg + 16'h1 : 16'h1;
      dc_reg  <= lamps.dc_ok;
      ovl_reg <= (cond == 13'h0020 && main_out_en) ?
                 ovl_reg + 16'h1 : 16'h0;
      run_reg <= (power_good_n == pg_reg) ? run_reg + 16'h1 : 16'h1;
      pg_reg  <= power_good_n;
    end
  end
  sequence s_store;  // One store request
    store_cmd ##1 !store_cmd;
  endsequence
  sequence s_oc_bad;  // Unsupported over-current code
    oc_wr && !ot_wr && !(wr_data inside {8'hc0, 8'hf8});
  endsequence
  sequence s_bus_on;  // Bus mode, control pin grounded
    (!protocol_terminated && on_off_at_ground) [*4];
  endsequence
  chk_present_low: assert property (!module_present_n)
    else $error("module present line not low");
  chk_shut_lines: assert property (cond.ot_shutdown |=>
    !fault_n && !power_good_n && lamps.red && !lamps.dc_ok)
    else $error("thermal shutdown pattern wrong");
  chk_hard_fault: assert property ((cond.fuse_blown ||
    cond.boost_fail || cond.ov_latched) && !cond.ot_shutdown |=>
    lamps == 4'b1001 && !fault_n && !power_good_n)
    else $error("hard fault pattern wrong");
  chk_loss_pg: assert property (
    cond.loss_imminent && !cond.overload |=> !power_good_n)
    else $error("power good not low on imminent loss");
  chk_pg_pulse: assert property (ovl_reg > 3 * PG_CYCLES &&
    power_good_n != pg_reg |-> run_reg == PG_CYCLES)
    else $error("power good pulse length wrong");
  chk_blink_rate: assert property (ovl_reg > 3 * BLINK_CYCLES &&
    lamps.dc_ok != dc_reg |-> blk_reg == BLINK_CYCLES)
    else $error("output lamp blink period wrong");
  chk_oc_reject: assert property (
    s_oc_bad |=> resp_reject && $stable(oc_resp))
    else $error("bad over-current code not refused");
  chk_ot_accept: assert property (ot_wr && !oc_wr &&
    wr_data inside {8'h80, 8'hc0} |=> ot_resp == $past(wr_data))
    else $error("good over-temperature code not taken");
  chk_store_pulse: assert property (s_store |-> nv_wr &&
    nv_data == {$past(ot_resp), $past(oc_resp)} ##1 !nv_wr)
    else $error("store pulse or data wrong");
  chk_alert_level: assert property (1'b1 |=>
    alert_n == ((|$past(fault_status)) ? 2'b00 : 2'b11))
    else $error("alert lines do not follow status");
  chk_addr_order: assert property (!$past(rst) |->
    addr_low == {$past(addr_sel_first), $past(addr_sel_second)})
    else $error("address nibble wrong");
  chk_mode_sel: assert property (!$past(rst) |->
    mode == aise_mode_t'($past(protocol_terminated)))
    else $error("mode does not follow protocol pin");
  chk_out_on: assert property (s_bus_on |-> main_out_en)
    else $error("output not on with pin grounded");
  chk_rs_interlock: assert property (
    (protocol_terminated && !interlock_on) [*4] |-> !main_out_en)
    else $error("output on without interlock");
endmodule : aise_chk
bind aise_top aise_chk #(.BLINK_CYCLES(BLINK_CYCLES),
  .PG_CYCLES(PG_CYCLES)) u_aise_chk (.*);

// ===== aise_top_tb.sv
// Self-checking bench of the status encoder
`define AISE_CMP(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t exp=%h got=%h", $time, (b), (a)); end end
module aise_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aise_pkg::*;
  logic        mclk, rst, off_cmd, on_cmd, clear_faults;
  logic        oc_wr, ot_wr, store_cmd, req_rs485, req_on;
  logic        protocol_terminated, on_off_at_ground, interlock_on;
  logic        fault_n, overtemp_warn_n, power_good_n, module_present_n;
  logic        main_out_en, resp_reject, nv_wr;
  logic [1:0]  addr_sel_first, addr_sel_second, alert_n;
  logic [3:0]  req_addr, addr_low;
  logic [7:0]  wr_data, oc_resp, ot_resp, v, oc_e, ot_e;
  logic [8:0]  fault_status;
  logic [15:0] nv_data;
  aise_cond_t  cond;
  aise_lamps_t lamps;
  aise_mode_t  mode;
  logic [37:0] q[$];  // Notes: kind, mask, expected
  logic [37:0] nt;    // Note under comparison
  int          n_fail, checked, cyc, seed;
  logic [7:0]  codes[5] = '{8'hc0, 8'hf8, 8'h80, 8'h00, 8'hff};
  aise_top #(.BLINK_CYCLES(8), .PG_CYCLES(4)) u_aise_top (.*);
  aise_shelf u_aise_shelf (.*);
  // Free running 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Observed value of one kind of note
  function automatic logic [17:0] obs(input logic [1:0] k);
    case (k)
      2'd0: obs = {10'h0, lamps, fault_n, overtemp_warn_n, power_good_n,
                   module_present_n};
      2'd1: obs = {2'b0, ot_resp, oc_resp};
      default: obs = {1'b0, alert_n, main_out_en, mode, addr_low,
                      fault_status};
    endcase
  endfunction : obs
  // Expected lamps and lines with mask of blinking bits and RS485 standby lines
  function automatic logic [15:0] exp_st(input aise_cond_t c,
                                         input logic rs, input logic on);
    logic [7:0] e;
    logic [7:0] m;
    e = 8'b1100_1110;
    m = 8'hff;
    if (c.ot_shutdown) e = 8'b1011_0000;
    else if (c.fuse_blown || c.boost_fail || c.ov_latched) e = 8'h94;
    else if (c.ac_absent) e = 8'h0c;
    else if (c.ac_bad) begin e = 8'h0c; m = 8'h7f; end
    else if (rs && !on) begin e = 8'h8c; m = 8'hf1; end
    else if (c.remote_standby && !rs) e = 8'h8c;
    else if (c.overload) begin e = 8'h8c; m = 8'hbd; end
    else if (c.internal_fault) e = 8'hd6;
    else if (c.ot_warn) e = 8'hea;
    else if (c.comm_lost && rs) m = 8'hef;
    else if (c.service_req && !rs) m = 8'hdf;
    if (c.loss_imminent && !c.overload) e[1] = 1'b0;
    return {e, m};
  endfunction : exp_st
  // Let outputs settle, then leave a note
  task automatic note(input logic [1:0] k, input logic [17:0] e, m);
    repeat (3) @(negedge mclk);
    q.push_back({k, m, e});
  endtask : note
  // Note the lamp and line pattern for present inputs
  task automatic st();
    logic [15:0] x;
    x = exp_st(cond, req_rs485, req_on);
    note(2'd0, {10'h0, x[15:8]}, {10'h0, x[7:0]});
  endtask : st
  // One-cycle pulse on a strobe
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse
  // Print counts and verdict, then stop
  task report_and_stop();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // Compare the oldest note with what the outputs show
  always @(posedge mclk) begin
    while (q.size() > 0) begin
      nt = q.pop_front();
      `AISE_CMP(obs(nt[37:36]) & nt[35:18], nt[17:0] & nt[35:18])
    end
  end
  // Cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    {rst, req_on} = 2'b11;
    {off_cmd, on_cmd, clear_faults, oc_wr, ot_wr, store_cmd} = '0;
    {req_rs485, req_addr, wr_data, cond} = '0;
    {oc_e, ot_e} = {8'hf8, 8'hc0};
    seed = $urandom(32'h6ac6d28a);
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    note(2'd1, 18'h0c0f8, 18'h0ffff);
    for (int i = 0; i < 14; i++) begin
      cond = aise_cond_t'(13'h1 << i);
      st();
    end
    cond = aise_cond_t'(13'h0020);
    repeat (60) @(negedge mclk);
    cond = '0;
    pulse(clear_faults);
    note(2'd2, 18'h18000, 18'h181ff);
    cond.internal_fault = 1'b1;
    @(negedge mclk);
    cond = '0;
    note(2'd2, 18'h00001, 18'h181ff);
    cond.internal_fault = 1'b1;
    pulse(clear_faults);
    note(2'd2, 18'h00001, 18'h001ff);
    cond = '0;
    for (int i = 0; i < 8; i++) begin
      v = (i < 5) ? codes[i] : 8'($urandom);
      wr_data = v;
      pulse(oc_wr);
      if (v inside {8'hc0, 8'hf8}) oc_e = v;
      pulse(ot_wr);
      if (v inside {8'h80, 8'hc0}) ot_e = v;
      note(2'd1, {2'b0, ot_e, oc_e}, 18'h0ffff);
      pulse(store_cmd);
    end
    for (int i = 0; i < 4; i++) begin
      req_addr = 4'($urandom);
      req_rs485 = i[0];
      note(2'd2, {4'h0, req_rs485, req_addr, 9'h0}, 18'h03e00);
    end
    req_rs485 = 1'b1;
    cond.comm_lost = 1'b1;
    st();
    cond = '0;
    pulse(off_cmd);
    note(2'd2, 18'h0, 18'h04000);
    pulse(on_cmd);
    note(2'd2, 18'h04000, 18'h04000);
    req_on = 1'b0;
    st();
    note(2'd2, 18'h0, 18'h04000);
    repeat (2) @(negedge mclk);
    report_and_stop();
  end
endmodule : aise_top_tb
